// File: rtl/dcsr_regs.sv
// register bank: device mode, identification, streaming address control,
// sysref front-end controls and clock input control, reached over spi.
// assumes spi pins synchronous to i_clk and sclk much slower than i_clk.

// Contract
// - mode field 0 is normal and reset value, 3 is power down, 1-2 reserved.
// - class field in low nibble is read-only with a fixed code.
// - 16-bit family identifier reads a fixed code.
// - 16-bit maker identifier reads a fixed code.
// - address-freeze set keeps the streaming address fixed every byte.
// - address-freeze clear, the reset value, steps the address per direction bit.
// - direction bit 1 (default) increments, 0 decrements after each byte.
// - sysref control bit 6 enables the sysref processor, off after reset.
// - sysref control bit 5 enables the sysref receiver, off after reset.
// - bit 4 selects fine sysref window delay steps.
// - bits 3 to 0 choose the sysref sampling delay.
// - writing soft reset resets all registers, self-clears, lasts up to 750 ns.
module dcsr_regs
    import dcsr_pkg::*;
#(
    parameter logic [3:0]  CLASS_CODE  = 4'hA,    // arbitrary value
    parameter logic [15:0] FAMILY_CODE = 16'h1234, // arbitrary value
    parameter logic [15:0] MAKER_CODE  = 16'h5A5A  // arbitrary value
) (
    // clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_reset_n,
    // spi pins
    input  wire logic   i_spi_sclk,
    input  wire logic   i_spi_sdi,
    input  wire logic   i_spi_cs_n,
    output logic        o_spi_sdo,
    output logic        o_spi_sdo_oe,
    // device mode
    output logic [1:0]  o_operating_mode,
    output logic        o_power_down,
    output logic        o_soft_reset_active,
    // sysref front end
    output logic        o_sysref_receiver_on,
    output logic        o_sysref_processor_on,
    output logic        o_sysref_fine_window,
    output logic [3:0]  o_sysref_delay_choice,
    // clock input control
    output logic [7:0]  o_clock_input_control
);
    import dcsr_pkg::*;

    dcsr_spi_if bus ();

    logic [7:0]         cfga_ff;
    logic [7:0]         opmode_ff;
    logic [3:0]         class_rsv_ff;
    logic [7:0]         stream_ff;
    logic [7:0]         sysref_ff;
    logic [7:0]         clkin_ff;
    logic [ADDR_W-1:0]  ptr_ff;
    logic [ADDR_W-1:0]  nxt_ptr;
    logic [SRST_CW-1:0] srst_cnt_ff;
    logic               srst_active_ff;
    logic               pd_ff;
    logic               wr_en;
    logic               srst_go;
    logic [7:0]         rd_mux;

    // ------------------------------------------------------------------
    // serial front end
    // ------------------------------------------------------------------
    dcsr_spi_shift u_shift (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_sclk    (i_spi_sclk),
        .i_sdi     (i_spi_sdi),
        .i_cs_n    (i_spi_cs_n),
        .o_sdo     (o_spi_sdo),
        .o_sdo_oe  (o_spi_sdo_oe),
        .bus       (bus.front)
    );

    assign wr_en   = bus.byte_stb & ~bus.rd_nwr;
    assign srst_go = wr_en && (ptr_ff == ADDR_CFG_A) && bus.wr_data[CFG_SRST_BIT];

    // ------------------------------------------------------------------
    // soft reset timer
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            srst_cnt_ff    <= '0;
            srst_active_ff <= 1'b0;
        end else if (srst_go) begin
            srst_cnt_ff    <= SRST_CYC;
            srst_active_ff <= 1'b1;
        end else if (srst_cnt_ff != '0) begin
            srst_cnt_ff    <= srst_cnt_ff - SRST_ONE;
            srst_active_ff <= (srst_cnt_ff != SRST_ONE);
        end
    end

    // spi front end is held idle while the soft reset runs
    assign bus.hold_off = srst_active_ff;

    // ------------------------------------------------------------------
    // streaming address pointer
    // ------------------------------------------------------------------
    always_comb begin
        nxt_ptr = ptr_ff;
        if (bus.hdr_stb) begin
            nxt_ptr = bus.hdr_addr;
        end else if (bus.byte_stb && !stream_ff[STREAM_HOLD_BIT]) begin
            if (cfga_ff[CFG_ASCEND_BIT]) begin
                nxt_ptr = ptr_ff + ADDR_STEP;
            end else begin
                nxt_ptr = ptr_ff - ADDR_STEP;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ptr_ff <= '0;
        end else begin
            ptr_ff <= nxt_ptr;
        end
    end

    // ------------------------------------------------------------------
    // writable registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfga_ff <= CFG_A_RST;
        end else if (srst_go) begin
            cfga_ff <= CFG_A_RST;
        end else if (wr_en && (ptr_ff == ADDR_CFG_A)) begin
            cfga_ff <= {1'b0, bus.wr_data[CFG_ASCEND_BIT+1:CFG_ASCEND_BIT], 1'b1, bus.wr_data[CFG_SDO_BIT-1:0]};
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            opmode_ff <= OPMODE_RST;
        end else if (srst_go) begin
            opmode_ff <= OPMODE_RST;
        end else if (wr_en && (ptr_ff == ADDR_OPMODE)) begin
            opmode_ff <= bus.wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            class_rsv_ff <= CLASS_RSV_RST;
        end else if (srst_go) begin
            class_rsv_ff <= CLASS_RSV_RST;
        end else if (wr_en && (ptr_ff == ADDR_CLASS)) begin
            class_rsv_ff <= bus.wr_data[DATA_W-1:CLASS_MSB+1];
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            stream_ff <= STREAM_RST;
        end else if (srst_go) begin
            stream_ff <= STREAM_RST;
        end else if (wr_en && (ptr_ff == ADDR_STREAM)) begin
            stream_ff <= bus.wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sysref_ff <= SYSREF_RST;
        end else if (srst_go) begin
            sysref_ff <= SYSREF_RST;
        end else if (wr_en && (ptr_ff == ADDR_SYSREF)) begin
            sysref_ff <= bus.wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            clkin_ff <= CLKIN_RST;
        end else if (srst_go) begin
            clkin_ff <= CLKIN_RST;
        end else if (wr_en && (ptr_ff == ADDR_CLKIN)) begin
            clkin_ff <= bus.wr_data;
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pd_ff <= 1'b0;
        end else begin
            pd_ff <= (opmode_ff[MODE_MSB:0] == MODE_PWRDN);
        end
    end

    // ------------------------------------------------------------------
    // read path
    // ------------------------------------------------------------------
    always_comb begin
        unique case (ptr_ff)
            ADDR_CFG_A:     rd_mux = cfga_ff;
            ADDR_OPMODE:    rd_mux = opmode_ff;
            ADDR_CLASS:     rd_mux = {class_rsv_ff, CLASS_CODE};
            ADDR_FAMILY_LO: rd_mux = FAMILY_CODE[7:0];
            ADDR_FAMILY_HI: rd_mux = FAMILY_CODE[15:8];
            ADDR_MAKER_LO:  rd_mux = MAKER_CODE[7:0];
            ADDR_MAKER_HI:  rd_mux = MAKER_CODE[15:8];
            ADDR_STREAM:    rd_mux = stream_ff;
            ADDR_SYSREF:    rd_mux = sysref_ff;
            ADDR_CLKIN:     rd_mux = clkin_ff;
            default:        rd_mux = UNMAPPED_DATA;
        endcase
    end

    assign bus.rd_data = rd_mux;

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign o_operating_mode      = opmode_ff[MODE_MSB:0];
    assign o_power_down          = pd_ff;
    assign o_soft_reset_active   = srst_active_ff;
    assign o_sysref_processor_on = sysref_ff[SR_PROC_BIT];
    assign o_sysref_receiver_on  = sysref_ff[SR_RECV_BIT];
    assign o_sysref_fine_window  = sysref_ff[SR_ZOOM_BIT];
    assign o_sysref_delay_choice = sysref_ff[SR_SEL_MSB:0];
    assign o_clock_input_control = clkin_ff;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_mode_pd;
        @(posedge i_clk) disable iff (!i_reset_n)
        (o_operating_mode == MODE_PWRDN) ##1 (o_operating_mode == MODE_PWRDN) |-> o_power_down;
    endproperty
    a_mode_pd: assert property (p_mode_pd) else $error("power down not flagged for mode 3");

    property p_srst_defaults;
        @(posedge i_clk) disable iff (!i_reset_n)
        srst_go |=> (opmode_ff == OPMODE_RST) && (sysref_ff == SYSREF_RST) && (stream_ff == STREAM_RST)
                    && cfga_ff[CFG_ASCEND_BIT];
    endproperty
    a_srst_defaults: assert property (p_srst_defaults) else $error("soft reset left a register set");

    property p_srst_len;
        @(posedge i_clk) disable iff (!i_reset_n)
        srst_go |=> o_soft_reset_active [*8] ##1 o_soft_reset_active [*7] ##1 !o_soft_reset_active;
    endproperty
    a_srst_len: assert property (p_srst_len) else $error("soft reset interval length wrong");

    property p_class_ro;
        @(posedge i_clk) disable iff (!i_reset_n)
        (ptr_ff == ADDR_CLASS) |-> (bus.rd_data[CLASS_MSB:0] == CLASS_CODE);
    endproperty
    a_class_ro: assert property (p_class_ro) else $error("class code not returned");

    property p_family;
        @(posedge i_clk) disable iff (!i_reset_n)
        (ptr_ff == ADDR_FAMILY_LO) || (ptr_ff == ADDR_FAMILY_HI)
            |-> (bus.rd_data == ((ptr_ff == ADDR_FAMILY_HI) ? FAMILY_CODE[15:8] : FAMILY_CODE[7:0]));
    endproperty
    a_family: assert property (p_family) else $error("family code changed");

    property p_maker;
        @(posedge i_clk) disable iff (!i_reset_n)
        (ptr_ff == ADDR_MAKER_LO) || (ptr_ff == ADDR_MAKER_HI)
            |-> (bus.rd_data == ((ptr_ff == ADDR_MAKER_HI) ? MAKER_CODE[15:8] : MAKER_CODE[7:0]));
    endproperty
    a_maker: assert property (p_maker) else $error("maker code wrong");

    property p_hold;
        @(posedge i_clk) disable iff (!i_reset_n)
        bus.byte_stb && stream_ff[STREAM_HOLD_BIT] |=> (ptr_ff == $past(ptr_ff));
    endproperty
    a_hold: assert property (p_hold) else $error("address moved while frozen");

    property p_ascend;
        @(posedge i_clk) disable iff (!i_reset_n)
        bus.byte_stb && !stream_ff[STREAM_HOLD_BIT] && cfga_ff[CFG_ASCEND_BIT]
            |=> (ptr_ff == $past(ptr_ff) + ADDR_STEP);
    endproperty
    a_ascend: assert property (p_ascend) else $error("address did not increment");

    property p_descend;
        @(posedge i_clk) disable iff (!i_reset_n)
        bus.byte_stb && !stream_ff[STREAM_HOLD_BIT] && !cfga_ff[CFG_ASCEND_BIT]
            |=> (ptr_ff == $past(ptr_ff) - ADDR_STEP);
    endproperty
    a_descend: assert property (p_descend) else $error("address did not decrement");

    property p_sysref_wr;
        @(posedge i_clk) disable iff (!i_reset_n)
        wr_en && (ptr_ff == ADDR_SYSREF)
            |=> (o_sysref_processor_on == $past(bus.wr_data[SR_PROC_BIT]))
                && (o_sysref_receiver_on == $past(bus.wr_data[SR_RECV_BIT]))
                && (o_sysref_fine_window == $past(bus.wr_data[SR_ZOOM_BIT]))
                && (o_sysref_delay_choice == $past(bus.wr_data[SR_SEL_MSB:0]));
    endproperty
    a_sysref_wr: assert property (p_sysref_wr) else $error("sysref controls not taken");

endmodule

// File: rtl/dcsr_pkg.sv
// package: address map, field layout, reset values and timing of the
// configuration and sysref register bank.
// assumes a single 20 MHz system clock; spi pins are synchronous to it.
package dcsr_pkg;

    // ------------------------------------------------------------------
    // spi frame shape
    // ------------------------------------------------------------------
    localparam int          ADDR_W     = 15;
    localparam int          DATA_W     = 8;
    localparam int          HDR_BITS   = 24;
    localparam int          HDR_CW     = 5;
    localparam int          BIT_CW     = 3;
    localparam logic [4:0]  HDR_LAST   = 5'h17;
    localparam logic [2:0]  BYTE_LAST  = 3'h7;
    localparam logic [2:0]  BYTE_FIRST = 3'h0;
    localparam int          HDR_RW_BIT = 23;

    // ------------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------------
    localparam logic [14:0] ADDR_CFG_A     = 15'h0000;
    localparam logic [14:0] ADDR_OPMODE    = 15'h0002;
    localparam logic [14:0] ADDR_CLASS     = 15'h0003;
    localparam logic [14:0] ADDR_FAMILY_LO = 15'h0004;
    localparam logic [14:0] ADDR_FAMILY_HI = 15'h0005;
    localparam logic [14:0] ADDR_MAKER_LO  = 15'h000C;
    localparam logic [14:0] ADDR_MAKER_HI  = 15'h000D;
    localparam logic [14:0] ADDR_STREAM    = 15'h0010;
    localparam logic [14:0] ADDR_SYSREF    = 15'h0029;
    localparam logic [14:0] ADDR_CLKIN     = 15'h002A;
    localparam logic [14:0] ADDR_STEP      = 15'h0001;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int CFG_SRST_BIT    = 7;
    localparam int CFG_ASCEND_BIT  = 5;
    localparam int CFG_SDO_BIT     = 4;
    localparam int MODE_MSB        = 1;
    localparam int CLASS_MSB       = 3;
    localparam int STREAM_HOLD_BIT = 0;
    localparam int SR_PROC_BIT     = 6;
    localparam int SR_RECV_BIT     = 5;
    localparam int SR_ZOOM_BIT     = 4;
    localparam int SR_SEL_MSB      = 3;

    // ------------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CFG_A_RST      = 8'h30;
    localparam logic [7:0] OPMODE_RST     = 8'h00;
    localparam logic [3:0] CLASS_RSV_RST  = 4'h0;
    localparam logic [7:0] STREAM_RST     = 8'h00;
    localparam logic [7:0] SYSREF_RST     = 8'h00;
    localparam logic [7:0] CLKIN_RST      = 8'h00;
    localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
    localparam logic [1:0] MODE_NORMAL    = 2'h0;
    localparam logic [1:0] MODE_PWRDN     = 2'h3;

    // ------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------
    localparam int         CLK_MHZ  = 20;
    localparam int         SRST_NS  = 750;
    localparam int         SRST_CW  = 5;
    // longest time, rounded down to whole cycles
    localparam logic [4:0] SRST_CYC = SRST_CW'(SRST_NS * CLK_MHZ / 1000);
    localparam logic [4:0] SRST_ONE = 5'h01;

    typedef enum logic [2:0] {
        PH_IDLE = 3'b001,
        PH_HDR  = 3'b010,
        PH_DATA = 3'b100
    } dcsr_phase_e;

endpackage

// File: rtl/dcsr_spi_if.sv
// interface: byte level link between the spi shifter and the register bank.
// assumes both ends run on the same clock.
interface dcsr_spi_if;
    logic        hdr_stb;
    logic        rd_nwr;
    logic [14:0] hdr_addr;
    logic        byte_stb;
    logic [7:0]  wr_data;
    logic [7:0]  rd_data;
    logic        hold_off;

    modport front (output hdr_stb, rd_nwr, hdr_addr, byte_stb, wr_data,
                   input  rd_data, hold_off);
    modport bank  (input  hdr_stb, rd_nwr, hdr_addr, byte_stb, wr_data,
                   output rd_data, hold_off);
endinterface

// File: rtl/dcsr_spi_shift.sv
// spi shifter: turns the serial frame into header and byte strobes.
// assumes sclk idles low, data sampled on rising edge, sdo changed on falling,
// and each sclk half period spans at least four system clocks.
module dcsr_spi_shift
    import dcsr_pkg::*;
(
    // clock and reset
    input  wire logic   i_clk,
    input  wire logic   i_reset_n,
    // spi pins
    input  wire logic   i_sclk,
    input  wire logic   i_sdi,
    input  wire logic   i_cs_n,
    output logic        o_sdo,
    output logic        o_sdo_oe,
    // byte link
    dcsr_spi_if.front   bus
);
    import dcsr_pkg::*;

    dcsr_phase_e         phase_ff;
    logic                sclk_ff;
    logic [HDR_CW-1:0]   hcnt_ff;
    logic [BIT_CW-1:0]   bcnt_ff;
    logic [HDR_BITS-2:0] sh_ff;
    logic [DATA_W-1:0]   out_ff;
    logic                rise;
    logic                fall;
    logic                abort;

    assign rise  = i_sclk & ~sclk_ff;
    assign fall  = ~i_sclk & sclk_ff;
    assign abort = i_cs_n | bus.hold_off;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sclk_ff <= 1'b0;
        end else begin
            sclk_ff <= i_sclk;
        end
    end

    // ------------------------------------------------------------------
    // frame phase and bit counting
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            phase_ff     <= PH_IDLE;
            hcnt_ff      <= '0;
            bcnt_ff      <= '0;
            sh_ff        <= '0;
            bus.hdr_stb  <= 1'b0;
            bus.byte_stb <= 1'b0;
            bus.rd_nwr   <= 1'b0;
            bus.hdr_addr <= '0;
            bus.wr_data  <= '0;
        end else begin
            bus.hdr_stb  <= 1'b0;
            bus.byte_stb <= 1'b0;
            if (abort) begin
                phase_ff <= PH_IDLE;
                hcnt_ff  <= '0;
                bcnt_ff  <= '0;
            end else begin
                unique case (phase_ff)
                    PH_IDLE: begin
                        phase_ff <= PH_HDR;
                    end
                    PH_HDR: begin
                        if (rise) begin
                            sh_ff   <= {sh_ff[HDR_BITS-3:0], i_sdi};
                            hcnt_ff <= hcnt_ff + 5'h01;
                            if (hcnt_ff == HDR_LAST) begin
                                phase_ff     <= PH_DATA;
                                bus.hdr_stb  <= 1'b1;
                                bus.rd_nwr   <= sh_ff[HDR_RW_BIT-1];
                                bus.hdr_addr <= {sh_ff[ADDR_W-2:0], i_sdi};
                            end
                        end
                    end
                    PH_DATA: begin
                        if (rise) begin
                            sh_ff   <= {sh_ff[HDR_BITS-3:0], i_sdi};
                            bcnt_ff <= bcnt_ff + 3'h1;
                            if (bcnt_ff == BYTE_LAST) begin
                                bus.byte_stb <= 1'b1;
                                bus.wr_data  <= {sh_ff[DATA_W-2:0], i_sdi};
                            end
                        end
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // read data out, msb first, changed on falling sclk
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_sdo    <= 1'b0;
            o_sdo_oe <= 1'b0;
            out_ff   <= '0;
        end else begin
            o_sdo_oe <= (phase_ff == PH_DATA) && bus.rd_nwr && !abort;
            if ((phase_ff == PH_DATA) && bus.rd_nwr && fall) begin
                if (bcnt_ff == BYTE_FIRST) begin
                    o_sdo  <= bus.rd_data[DATA_W-1];
                    out_ff <= {bus.rd_data[DATA_W-2:0], 1'b0};
                end else begin
                    o_sdo  <= out_ff[DATA_W-1];
                    out_ff <= {out_ff[DATA_W-2:0], 1'b0};
                end
            end
        end
    end

endmodule

// File: bench/dcsr_host_model.sv
// spi host model: drives mode 0 frames into the register bank.
// assumes frame() is called just after a rising i_clk edge.
module dcsr_host_model (
    // clock and read data
    input  wire logic i_clk,
    input  wire logic i_sdo,
    input  wire logic i_sdo_oe,
    // spi pins driven
    output logic      o_sclk,
    output logic      o_sdi,
    output logic      o_cs_n
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        o_sclk = 1'b0;
        o_sdi  = 1'b0;
        o_cs_n = 1'b1;
    end
    // four clocks per sclk phase
    task automatic half;
        repeat (4) @(posedge i_clk);
        #1;
    endtask
    task automatic frame(input logic rd, input logic [14:0] a, input int n,
                         input logic [15:0] wd, output logic [15:0] q);
        logic [39:0] sh;
        sh = {rd, 8'h00, a, (n == 1) ? {wd[7:0], 8'h00} : wd};
        q = 16'h0000;
        o_cs_n = 1'b0;
        for (int i = 0; i < 24 + 8 * n; i++) begin
            o_sdi = sh[39];
            half();
            // an undriven sdo shows the inverse of its last bit
            q = {q[14:0], i_sdo_oe ? i_sdo : ~i_sdo};
            o_sclk = 1'b1;
            half();
            o_sclk = 1'b0;
            sh = sh << 1;
        end
        half();
        // released line shows the inverse of its last bit
        o_sdi  = ~o_sdi;
        o_cs_n = 1'b1;
        half();
    endtask
endmodule

// File: bench/test_device_config_sysref_regs.sv
// bench: register traffic through the spi host model, then awkward cases.
// assumes the package and register bank under rtl/.
module test_device_config_sysref_regs;
    timeunit 1ns;
    timeprecision 1ns;
    import dcsr_pkg::*;
    typedef struct packed {logic [14:0] a; logic [7:0] wd; logic [7:0] rd;} dcsr_row_s;
    logic        clk, rst_n, sclk, sdi, cs_n, sdo, oe, pdn, srst, rcv, prc, fine;
    logic [1:0]  mode;
    logic [3:0]  dly;
    logic [7:0]  cic;
    logic [15:0] q;
    int          error_cnt, compares, cyc, srst_cnt;
    logic [14:0] zr [4] = '{ADDR_OPMODE, ADDR_STREAM, ADDR_SYSREF, ADDR_CLKIN};
    dcsr_row_s   rows [12] = '{'{15'h0002, 8'h03, 8'h03}, '{15'h0002, 8'hFE, 8'hFE},
        '{15'h0003, 8'h55, 8'h56}, '{15'h0004, 8'hFF, 8'hE1}, '{15'h0005, 8'h00, 8'hC3},
        '{15'h000C, 8'h00, 8'h2D}, '{15'h000D, 8'hFF, 8'h7B}, '{15'h0029, 8'h20, 8'h20},
        '{15'h0029, 8'h6F, 8'h6F}, '{15'h002A, 8'hA5, 8'hA5}, '{15'h0040, 8'hFF, 8'h00},
        '{15'h0000, 8'h2F, 8'h3F}};
    // identification values are arbitrary
    dcsr_regs #(.CLASS_CODE(4'h6), .FAMILY_CODE(16'hC3E1), .MAKER_CODE(16'h7B2D)) dut (
        .i_clk(clk), .i_reset_n(rst_n), .i_spi_sclk(sclk), .i_spi_sdi(sdi),
        .i_spi_cs_n(cs_n), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe), .o_operating_mode(mode),
        .o_power_down(pdn), .o_soft_reset_active(srst), .o_sysref_receiver_on(rcv),
        .o_sysref_processor_on(prc), .o_sysref_fine_window(fine),
        .o_sysref_delay_choice(dly), .o_clock_input_control(cic));
    dcsr_host_model host (.i_clk(clk), .i_sdo(sdo), .i_sdo_oe(oe), .o_sclk(sclk), .o_sdi(sdi),
        .o_cs_n(cs_n));
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (srst === 1'b1) srst_cnt++;
        if (cyc == 30000) begin
            error_cnt++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        host.frame(1'b0, a, 1, {8'h00, d}, q);
    endtask
    task automatic rdc(input logic [14:0] a, input logic [15:0] e, input int n);
        host.frame(1'b1, a, n, 16'h0000, q);
        chk((n == 1) ? {8'h00, q[7:0]} : q, e);
    endtask
    task automatic tally_and_finish;
        if (error_cnt == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #1;
        chk(16'({rcv, prc, fine, dly, mode, pdn, srst}), 16'h0000);
        rdc(ADDR_CFG_A, 16'h0030, 1);
        for (int i = 0; i < 4; i++) rdc(zr[i], 16'h0000, 1);
        // receiver row precedes processor row
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].wd);
            rdc(rows[i].a, {8'h00, rows[i].rd}, 1);
        end
        chk(16'({rcv, prc, fine, dly, mode, pdn}), 16'h037C);
        wr(ADDR_OPMODE, 8'h03);
        chk(16'({mode, pdn}), 16'h0007);
        host.frame(1'b0, ADDR_SYSREF, 2, 16'h1122, q);
        chk(16'({dly, cic}), 16'h0122);
        wr(ADDR_CFG_A, 8'h00);
        host.frame(1'b0, ADDR_CLKIN, 2, 16'h3344, q);
        chk(16'({dly, cic}), 16'h0433);
        wr(ADDR_STREAM, 8'h01);
        host.frame(1'b0, ADDR_CLKIN, 2, 16'h5566, q);
        chk(16'({dly, cic}), 16'h0466);
        rdc(ADDR_CLKIN, 16'h6666, 2);
        wr(ADDR_CFG_A, 8'h80);
        repeat (20) @(posedge clk);
        #1;
        chk(16'(srst_cnt), 16'h000F);
        rdc(ADDR_CFG_A, 16'h0030, 1);
        for (int i = 0; i < 4; i++) rdc(zr[i], 16'h0000, 1);
        wr(ADDR_SYSREF, 8'h20);
        wr(ADDR_SYSREF, 8'h60);
        chk(16'({rcv, prc, dly}), 16'h0030);
        wr(ADDR_SYSREF, 8'h70);
        chk(16'({fine, dly}), 16'h0010);
        tally_and_finish();
    end
endmodule
